// ==== design/icr_config_regs.sv ====
// Top of the configuration register bank with APB slave, event status and engine hookup.
//
// What this block does
// R1 - Six-bit flat threshold angle covering zero to 44.8 degrees.
// R2 - Flat event only after flat state held 0, 640, 1280 or 2560 ms.
// R3 - Programmable hysteresis keeps the flat decision from chattering.
// R4 - Gyro fast offset enable runs compensation on all three gyro axes.
// R5 - Per accel axis target: 00 off, 01 plus 1 g, 10 minus 1 g, 11 zero.
// R6 - Non-volatile programming allowed only while the permit bit is one.
// R7 - Wire-count bit zero gives 4-wire SPI, one gives 3-wire SPI.
// R8 - Port arrangement: auto/off, I2C/stabilizer, auto/magnetometer, 11 reserved.
// R9 - Every triggered gyro transition updates the reported gyro power state.
// R10 - Wake on any-motion and/or line one; both enabled means both needed.
// R11 - Sleep on no-motion, line one idle or line two; any one suffices.
// R12 - When wake and sleep fire together, wake wins and sleep is ignored.
// R13 - Line conditions follow the edge or level setting of each line.
// R14 - Sleep goes to suspend when depth bit is one, else fast start-up.
// R15 - Wake interrupt bit one raises an interrupt on each gyro wake-up while event mask bit zero is one.
// R16 - Host writes zero to reserved bits and ignores their read value.
// R17 - Wake judged only in low power, sleep only in normal running.
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
module icr_config_regs
	import icr_pkg::*;
#(
	parameter int HOLD_UNIT_CYC = FLAT_HOLD_UNIT_CYC
)
(
	input wire logic core_clk, // Core clock, 40 MHz.
	input wire logic sys_rst, // Synchronous reset, active high.
	input wire logic psel, // APB select.
	input wire logic penable, // APB enable.
	input wire logic pwrite, // APB direction, high for write.
	input wire logic [ADDR_W-1:0] paddr, // APB byte address.
	input wire logic [DATA_W-1:0] pwdata, // APB write data.
	output logic [DATA_W-1:0] prdata, // APB read data.
	output logic pready, // APB ready.
	output logic pslverr, // APB error on unmapped address.
	input wire logic [5:0] tiltAngle, // Tilt angle from the orientation path.
	input wire logic anyMotion, // Any-motion condition.
	input wire logic noMotion, // No-motion condition.
	input wire logic irqLineOne, // Interrupt line one level.
	input wire logic irqLineTwo, // Interrupt line two level.
	input wire logic nvmProgReq, // Request to program non-volatile memory.
	output logic nvmProgStrobe, // Gated programming request.
	output logic focGyroRun, // Gyro fast offset enabled.
	output logic [2:0] focAccAxisOn, // Accel axes with compensation on, x at bit 2.
	output logic [5:0] focAccTarget, // Accel targets, x in 5:4, z in 1:0.
	output logic threeWireSelect, // Primary port uses 3-wire SPI.
	output logic primaryI2c, // Primary port forced to I2C.
	output logic stabilizerLinkOn, // Secondary port used as stabilizer link.
	output logic magnetometerLinkOn, // Secondary port used for magnetometer.
	output logic [1:0] gyroPowerMode, // Reported gyro power mode.
	output logic flatState, // Qualified flat state.
	output logic irq // Interrupt, high while an unmasked event is pending.
);
	icr_core_if core ();

	logic [7:0] flatAngle_reg, flatAngle_next;
	logic [7:0] flatDelay_reg, flatDelay_next;
	logic [7:0] focSetup_reg, focSetup_next;
	logic [7:0] nvmGate_reg, nvmGate_next;
	logic [7:0] portSetup_reg, portSetup_next;
	logic [7:0] pwrTrig_reg, pwrTrig_next;
	logic [7:0] evtStatus_reg, evtStatus_next;
	logic [7:0] evtMask_reg, evtMask_next;
	logic [7:0] lineMode_reg, lineMode_next;
	logic [DATA_W-1:0] prdata_reg;
	logic [DATA_W-1:0] prdata_next;
	logic pready_reg;
	logic pready_next;
	logic pslverr_reg;
	logic pslverr_next;
	logic nvmStrobe_reg;
	logic nvmStrobe_next;
	logic focGyro_reg;
	logic [2:0] focAxisOn_reg;
	logic [2:0] focAxisOn_next;
	logic [5:0] focTarget_reg;
	logic threeWire_reg;
	logic primaryI2c_reg;
	logic stabLink_reg;
	logic magLink_reg;
	logic [1:0] pwrMode_reg;
	logic flatState_reg;
	logic irq_reg;
	logic irq_next;

	logic [7:0] regIdx;
	logic aligned;
	logic setupPhase;
	logic wrEn;
	logic selAngle, selDelay, selFoc, selNvm, selPort;
	logic selTrig, selPwrSt, selEvtSt, selMask, selLine;
	logic mapped;
	logic [7:0] wrByte;
	logic [7:0] rdByte;
	logic [7:0] pwrStatus;
	logic [7:0] evtSet;
	logic [7:0] evtClear;
	logic [1:0] portMode;

	// Address decode; a misaligned address matches nothing.
	assign regIdx = paddr[ADDR_W-1:2];
	assign aligned = (paddr[1:0] == 2'h0);
	assign selAngle = aligned && (regIdx == IDX_FLAT_ANGLE);
	assign selDelay = aligned && (regIdx == IDX_FLAT_DELAY);
	assign selFoc = aligned && (regIdx == IDX_FOC_SETUP);
	assign selNvm = aligned && (regIdx == IDX_NVM_GATE);
	assign selPort = aligned && (regIdx == IDX_PORT_SETUP);
	assign selTrig = aligned && (regIdx == IDX_PWR_TRIG);
	assign selPwrSt = aligned && (regIdx == IDX_PWR_STATUS);
	assign selEvtSt = aligned && (regIdx == IDX_EVT_STATUS);
	assign selMask = aligned && (regIdx == IDX_EVT_MASK);
	assign selLine = aligned && (regIdx == IDX_LINE_MODE);
	assign mapped = selAngle | selDelay | selFoc | selNvm | selPort | selTrig
		| selPwrSt | selEvtSt | selMask | selLine;

	// Phases: the reply is prepared in the setup cycle so pready stands one access cycle.
	assign setupPhase = psel && !penable;
	assign wrEn = psel && penable && pready_reg && pwrite;
	assign wrByte = pwdata[7:0];

	// Read mux; reserved bits were never stored, so they read as zero.
	assign pwrStatus = {5'h0, flatState_reg, pwrMode_reg}; // R9
	assign rdByte = selAngle ? flatAngle_reg
		: selDelay ? flatDelay_reg
		: selFoc ? focSetup_reg
		: selNvm ? nvmGate_reg
		: selPort ? portSetup_reg
		: selTrig ? pwrTrig_reg
		: selPwrSt ? pwrStatus
		: selEvtSt ? evtStatus_reg
		: selMask ? evtMask_reg
		: selLine ? lineMode_reg : 8'h00;
	assign prdata_next = setupPhase ? {24'h000000, rdByte} : prdata_reg;
	assign pready_next = setupPhase;
	assign pslverr_next = setupPhase && !mapped;

	// Register writes keep only the defined bits.
	assign flatAngle_next = (wrEn && selAngle) ? (wrByte & WM_FLAT_ANGLE) : flatAngle_reg; // R1
	assign flatDelay_next = (wrEn && selDelay) ? (wrByte & WM_FLAT_DELAY) : flatDelay_reg;
	assign focSetup_next = (wrEn && selFoc) ? (wrByte & WM_FOC_SETUP) : focSetup_reg;
	assign nvmGate_next = (wrEn && selNvm) ? (wrByte & WM_NVM_GATE) : nvmGate_reg;
	assign portSetup_next = (wrEn && selPort) ? (wrByte & WM_PORT_SETUP) : portSetup_reg;
	assign pwrTrig_next = (wrEn && selTrig) ? (wrByte & WM_PWR_TRIG) : pwrTrig_reg;
	assign evtMask_next = (wrEn && selMask) ? (wrByte & WM_EVT) : evtMask_reg;
	assign lineMode_next = (wrEn && selLine) ? (wrByte & WM_LINE_MODE) : lineMode_reg;

	// Sticky events; a new event in the clearing cycle survives because set is ORed last.
	assign evtSet = {6'h00, core.flatEvt,
		core.wakeEvt && pwrTrig_reg[WAKE_INT_BIT]}; // R15
	assign evtClear = (wrEn && selEvtSt) ? (wrByte & WM_EVT) : 8'h00;
	assign evtStatus_next = (evtStatus_reg & ~evtClear) | evtSet;
	assign irq_next = |(evtStatus_reg & evtMask_reg); // R15

	// Configuration fanned out to the engines.
	assign core.theta = flatAngle_reg[THETA_LSB +: 6]; // R1
	assign core.hyst = flatDelay_reg[HYST_LSB +: 3]; // R3
	assign core.holdSel = flatDelay_reg[HOLD_LSB +: 2]; // R2
	assign core.sleepSel = pwrTrig_reg[SLEEP_LSB +: 3]; // R11
	assign core.wakeSel = pwrTrig_reg[WAKE_LSB +: 2]; // R10
	assign core.sleepDeep = pwrTrig_reg[DEPTH_BIT]; // R14
	assign core.lineEdge = lineMode_reg[1:0]; // R13

	// Side outputs; the reserved arrangement code leaves every secondary use off.
	assign portMode = portSetup_reg[PORT_MODE_LSB +: 2];
	assign nvmStrobe_next = nvmProgReq && nvmGate_reg[NVM_PERMIT_BIT]; // R6
	assign focAxisOn_next = {focSetup_reg[FOC_Z_LSB + 4 +: 2] != FOC_AXIS_OFF,
		focSetup_reg[FOC_Z_LSB + 2 +: 2] != FOC_AXIS_OFF,
		focSetup_reg[FOC_Z_LSB +: 2] != FOC_AXIS_OFF}; // R5

	// Engines.
	icr_flat_detect #(
		.HOLD_UNIT_CYC(HOLD_UNIT_CYC)
	) flatEngine (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.tiltAngle(tiltAngle),
		.core(core.flat)
	);

	icr_power_trigger powerEngine (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.anyMotion(anyMotion),
		.noMotion(noMotion),
		.irqLineOne(irqLineOne),
		.irqLineTwo(irqLineTwo),
		.core(core.trig)
	);

	// Software-visible registers.
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			flatAngle_reg <= RST_FLAT_ANGLE;
			flatDelay_reg <= RST_FLAT_DELAY;
			focSetup_reg <= RST_ZERO;
			nvmGate_reg <= RST_ZERO;
			portSetup_reg <= RST_ZERO;
			pwrTrig_reg <= RST_ZERO;
			evtStatus_reg <= RST_ZERO;
			evtMask_reg <= RST_ZERO;
			lineMode_reg <= RST_ZERO;
		end
		else
		begin
			flatAngle_reg <= flatAngle_next;
			flatDelay_reg <= flatDelay_next;
			focSetup_reg <= focSetup_next;
			nvmGate_reg <= nvmGate_next;
			portSetup_reg <= portSetup_next;
			pwrTrig_reg <= pwrTrig_next;
			evtStatus_reg <= evtStatus_next;
			evtMask_reg <= evtMask_next;
			lineMode_reg <= lineMode_next;
		end
	end

	// Bus reply registers.
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			prdata_reg <= '0;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end
		else
		begin
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
		end
	end

	// Output flops keep every top-level output glitch free.
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			nvmStrobe_reg <= 1'b0;
			focGyro_reg <= 1'b0;
			focAxisOn_reg <= 3'h0;
			focTarget_reg <= 6'h00;
			threeWire_reg <= 1'b0;
			primaryI2c_reg <= 1'b0;
			stabLink_reg <= 1'b0;
			magLink_reg <= 1'b0;
			pwrMode_reg <= PMODE_NORMAL;
			flatState_reg <= 1'b0;
			irq_reg <= 1'b0;
		end
		else
		begin
			nvmStrobe_reg <= nvmStrobe_next; // R6
			focGyro_reg <= focSetup_reg[FOC_GYR_BIT]; // R4
			focAxisOn_reg <= focAxisOn_next; // R5
			focTarget_reg <= focSetup_reg[FOC_Z_LSB +: 6]; // R5
			threeWire_reg <= portSetup_reg[THREE_WIRE_BIT]; // R7
			primaryI2c_reg <= (portMode == PORT_I2C_STAB); // R8
			stabLink_reg <= (portMode == PORT_I2C_STAB); // R8
			magLink_reg <= (portMode == PORT_AUTO_MAG); // R8
			pwrMode_reg <= core.powerCode; // R9
			flatState_reg <= core.flatState;
			irq_reg <= irq_next;
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign nvmProgStrobe = nvmStrobe_reg;
	assign focGyroRun = focGyro_reg;
	assign focAccAxisOn = focAxisOn_reg;
	assign focAccTarget = focTarget_reg;
	assign threeWireSelect = threeWire_reg;
	assign primaryI2c = primaryI2c_reg;
	assign stabilizerLinkOn = stabLink_reg;
	assign magnetometerLinkOn = magLink_reg;
	assign gyroPowerMode = pwrMode_reg;
	assign flatState = flatState_reg;
	assign irq = irq_reg;
endmodule : icr_config_regs

// ==== design/icr_core_if.sv ====
// Interface carrying configuration and results between the register bank and its engines.
`timescale 1ns/1ps
interface icr_core_if;
	logic [5:0] theta;
	logic [2:0] hyst;
	logic [1:0] holdSel;
	logic flatState;
	logic flatEvt;
	logic [1:0] wakeSel;
	logic [2:0] sleepSel;
	logic sleepDeep;
	logic [1:0] lineEdge;
	logic [1:0] powerCode;
	logic wakeEvt;

	modport regs (output theta, hyst, holdSel, wakeSel, sleepSel, sleepDeep, lineEdge,
		input flatState, flatEvt, powerCode, wakeEvt);
	modport flat (input theta, hyst, holdSel, output flatState, flatEvt);
	modport trig (input wakeSel, sleepSel, sleepDeep, lineEdge, output powerCode, wakeEvt);
endinterface : icr_core_if

// ==== design/icr_flat_detect.sv ====
// Flat position decision with hysteresis and hold-time qualification.
`timescale 1ns/1ps
module icr_flat_detect
	import icr_pkg::*;
#(
	parameter int HOLD_UNIT_CYC = FLAT_HOLD_UNIT_CYC
)
(
	input wire logic core_clk, // Core clock.
	input wire logic sys_rst, // Synchronous reset, active high.
	input wire logic [5:0] tiltAngle, // Tilt angle code, same scale as threshold.
	icr_core_if.flat core // Flat configuration and results.
);
	logic rawFlat_reg;
	logic rawFlat_next;
	logic seenFlat_reg;
	logic seenFlat_next;
	logic evt_reg;
	logic evt_next;
	logic [HOLD_CNT_W-1:0] holdCnt_reg;
	logic [HOLD_CNT_W-1:0] holdCnt_next;
	logic [HOLD_CNT_W-1:0] holdTarget;
	logic [6:0] enterLimit;
	logic [6:0] exitLimit;
	logic settled;
	logic [HOLD_CNT_W-1:0] unitCyc;

	// Once flat, the angle must pass threshold plus hysteresis to leave, which stops chatter.
	assign enterLimit = {1'b0, core.theta}; // R1
	assign exitLimit = enterLimit + {4'h0, core.hyst}; // R3
	assign rawFlat_next = rawFlat_reg ? ({1'b0, tiltAngle} <= exitLimit)
		: ({1'b0, tiltAngle} <= enterLimit);

	// Hold target is zero, one, two or four time units.
	assign unitCyc = HOLD_CNT_W'(HOLD_UNIT_CYC);
	assign holdTarget = (core.holdSel == HOLD_NONE) ? '0
		: (core.holdSel == HOLD_ONE) ? unitCyc
		: (core.holdSel == HOLD_TWO) ? (unitCyc << 1) : (unitCyc << 2); // R2
	assign settled = (rawFlat_next == rawFlat_reg) && (holdCnt_reg >= holdTarget);
	assign holdCnt_next = (rawFlat_next != rawFlat_reg) ? '0
		: (holdCnt_reg < holdTarget) ? holdCnt_reg + 1'b1 : holdCnt_reg;
	assign seenFlat_next = (settled && (rawFlat_reg != seenFlat_reg)) ? rawFlat_reg
		: seenFlat_reg; // R2
	assign evt_next = settled && (rawFlat_reg != seenFlat_reg); // R2

	// State registers.
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			rawFlat_reg <= 1'b0;
			seenFlat_reg <= 1'b0;
			evt_reg <= 1'b0;
			holdCnt_reg <= '0;
		end
		else
		begin
			rawFlat_reg <= rawFlat_next;
			seenFlat_reg <= seenFlat_next;
			evt_reg <= evt_next;
			holdCnt_reg <= holdCnt_next;
		end
	end

	assign core.flatState = seenFlat_reg;
	assign core.flatEvt = evt_reg;
endmodule : icr_flat_detect

// ==== design/icr_pkg.sv ====
// Package with the register map, field layout and timing constants of the config bank.
package icr_pkg;

	// Bus geometry: the word index sits in paddr[9:2].
	localparam int ADDR_W = 10;
	localparam int DATA_W = 32;

	// Register indices; byte address is four times the index.
	localparam logic [7:0] IDX_FLAT_ANGLE = 8'h67;
	localparam logic [7:0] IDX_FLAT_DELAY = 8'h68;
	localparam logic [7:0] IDX_FOC_SETUP = 8'h69;
	localparam logic [7:0] IDX_NVM_GATE = 8'h6a;
	localparam logic [7:0] IDX_PORT_SETUP = 8'h6b;
	localparam logic [7:0] IDX_PWR_TRIG = 8'h6c;
	localparam logic [7:0] IDX_PWR_STATUS = 8'h80;
	localparam logic [7:0] IDX_EVT_STATUS = 8'h81;
	localparam logic [7:0] IDX_EVT_MASK = 8'h82;
	localparam logic [7:0] IDX_LINE_MODE = 8'h83;

	// Reset values.
	localparam logic [7:0] RST_FLAT_ANGLE = 8'h08;
	localparam logic [7:0] RST_FLAT_DELAY = 8'h11;
	localparam logic [7:0] RST_ZERO = 8'h00;

	// Writable bits; reserved bits stay zero and read as zero.
	localparam logic [7:0] WM_FLAT_ANGLE = 8'h3f;
	localparam logic [7:0] WM_FLAT_DELAY = 8'h37;
	localparam logic [7:0] WM_FOC_SETUP = 8'h7f;
	localparam logic [7:0] WM_NVM_GATE = 8'h02;
	localparam logic [7:0] WM_PORT_SETUP = 8'h31;
	localparam logic [7:0] WM_PWR_TRIG = 8'h7f;
	localparam logic [7:0] WM_EVT = 8'h03;
	localparam logic [7:0] WM_LINE_MODE = 8'h03;

	// Field positions.
	localparam int THETA_LSB = 0;
	localparam int HYST_LSB = 0;
	localparam int HOLD_LSB = 4;
	localparam int FOC_Z_LSB = 0;
	localparam int FOC_GYR_BIT = 6;
	localparam int NVM_PERMIT_BIT = 1;
	localparam int THREE_WIRE_BIT = 0;
	localparam int PORT_MODE_LSB = 4;
	localparam int SLEEP_LSB = 0;
	localparam int WAKE_LSB = 3;
	localparam int DEPTH_BIT = 5;
	localparam int WAKE_INT_BIT = 6;

	// Encodings.
	localparam logic [1:0] PORT_I2C_STAB = 2'h1;
	localparam logic [1:0] PORT_AUTO_MAG = 2'h2;
	localparam logic [1:0] FOC_AXIS_OFF = 2'h0;
	localparam logic [1:0] HOLD_NONE = 2'h0;
	localparam logic [1:0] HOLD_ONE = 2'h1;
	localparam logic [1:0] HOLD_TWO = 2'h2;
	localparam logic [1:0] PMODE_NORMAL = 2'h1;
	localparam logic [1:0] PMODE_FAST = 2'h3;
	localparam logic [1:0] PMODE_SUSPEND = 2'h0;

	// Gyro power states.
	typedef enum logic [2:0] {
		PWR_NORMAL = 3'b001,
		PWR_FAST = 3'b010,
		PWR_SUSPEND = 3'b100
	} icr_pwr_state_t;

	// Flat hold time base unit.
	localparam int FLAT_HOLD_UNIT_MS = 640;
	localparam int CLK_FREQ_KHZ = 40000;
	localparam int FLAT_HOLD_UNIT_CYC = FLAT_HOLD_UNIT_MS * CLK_FREQ_KHZ;
	localparam int HOLD_CNT_W = 28;

	// Judges an interrupt line as a level or as a rising edge of the wanted polarity.
	function automatic logic icr_line_cond(input logic now, input logic prev,
		input logic edgeMode, input logic invert);
		return edgeMode ? ((now ^ invert) & ~(prev ^ invert)) : (now ^ invert);
	endfunction : icr_line_cond

endpackage : icr_pkg

// ==== design/icr_power_trigger.sv ====
// Gyro power-mode engine driven by wake-up and sleep trigger conditions.
`timescale 1ns/1ps
module icr_power_trigger
	import icr_pkg::*;
(
	input wire logic core_clk, // Core clock.
	input wire logic sys_rst, // Synchronous reset, active high.
	input wire logic anyMotion, // Any-motion detector output.
	input wire logic noMotion, // No-motion detector output.
	input wire logic irqLineOne, // Level of interrupt line one.
	input wire logic irqLineTwo, // Level of interrupt line two.
	icr_core_if.trig core // Trigger configuration and results.
);
	icr_pwr_state_t state_reg;
	icr_pwr_state_t state_next;
	logic lineOnePrev_reg;
	logic lineTwoPrev_reg;
	logic [1:0] code_reg;
	logic [1:0] code_next;
	logic wakeEvt_reg;
	logic wakeHit;
	logic sleepHit;
	logic lineOneAct;
	logic lineOneIdle;
	logic lineTwoAct;
	logic lowPower;

	// Line conditions honour the edge or level signalling of each line.
	assign lineOneAct = icr_line_cond(irqLineOne, lineOnePrev_reg, core.lineEdge[0], 1'b0); // R13
	assign lineOneIdle = icr_line_cond(irqLineOne, lineOnePrev_reg, core.lineEdge[0], 1'b1); // R13
	assign lineTwoAct = icr_line_cond(irqLineTwo, lineTwoPrev_reg, core.lineEdge[1], 1'b0); // R13

	// Wake conditions are ANDed, sleep conditions ORed; an empty selection never fires.
	assign wakeHit = (core.wakeSel != 2'h0) && (!core.wakeSel[1] || anyMotion)
		&& (!core.wakeSel[0] || lineOneAct); // R10
	assign sleepHit = |(core.sleepSel & {noMotion, lineOneIdle, lineTwoAct}); // R11
	assign lowPower = (state_reg != PWR_NORMAL);

	// Next state: wake only from low power, sleep only from normal, and wake beats sleep.
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			PWR_NORMAL:
			begin
				if (sleepHit && !wakeHit) // R12 R17
					state_next = core.sleepDeep ? PWR_SUSPEND : PWR_FAST; // R14
			end
			PWR_FAST, PWR_SUSPEND:
			begin
				if (wakeHit) // R17
					state_next = PWR_NORMAL;
			end
			default:
				state_next = PWR_NORMAL;
		endcase
	end

	assign code_next = (state_next == PWR_NORMAL) ? PMODE_NORMAL
		: (state_next == PWR_FAST) ? PMODE_FAST : PMODE_SUSPEND; // R9

	// State, reported mode and edge history.
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			state_reg <= PWR_NORMAL;
			code_reg <= PMODE_NORMAL;
			wakeEvt_reg <= 1'b0;
			lineOnePrev_reg <= 1'b0;
			lineTwoPrev_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			code_reg <= code_next; // R9
			wakeEvt_reg <= lowPower && wakeHit;
			lineOnePrev_reg <= irqLineOne;
			lineTwoPrev_reg <= irqLineTwo;
		end
	end

	assign core.powerCode = code_reg;
	assign core.wakeEvt = wakeEvt_reg;
endmodule : icr_power_trigger

// ==== tb/icr_config_chk.sv ====
// Port-level assertions for the configuration register bank.
`timescale 1ns/1ps
module icr_config_chk
	import icr_pkg::*;
(
	input wire logic core_clk, // Clock.
	input wire logic sys_rst, // Reset.
	input wire logic psel, // Select.
	input wire logic penable, // Enable.
	input wire logic pwrite, // Direction.
	input wire logic pready, // Ready.
	input wire logic anyMotion, // Wake source.
	input wire logic noMotion, // Sleep source.
	input wire logic irqLineOne, // Line one.
	input wire logic irqLineTwo, // Line two.
	input wire logic nvmProgReq, // Request.
	input wire logic nvmProgStrobe, // Gated request.
	input wire logic [2:0] focAccAxisOn, // Axis enables.
	input wire logic [5:0] focAccTarget, // Targets.
	input wire logic [1:0] gyroPowerMode, // Mode.
	input wire logic irq // Interrupt.
);
	// One clock domain.
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);

	// A write counts only once the slave has answered it.
	wire logic apbWrite = psel && penable && pwrite && pready;

	a_ready_pulse: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("ready did not pulse once");
	a_foc_axis: assert property (focAccAxisOn == {|focAccTarget[5:4],
		|focAccTarget[3:2], |focAccTarget[1:0]}) else $error("axis enable wrong");
	a_nvm_gate: assert property (nvmProgStrobe |-> $past(nvmProgReq))
		else $error("strobe without request");
	a_mode_codes: assert property (gyroPowerMode != 2'h2)
		else $error("unused mode code");
	a_wake_cause: assert property (gyroPowerMode == PMODE_NORMAL &&
		$past(gyroPowerMode) != PMODE_NORMAL |-> $past(anyMotion || irqLineOne, 2))
		else $error("wake without cause");
	a_sleep_cause: assert property (gyroPowerMode != PMODE_NORMAL &&
		$past(gyroPowerMode) == PMODE_NORMAL |->
		$past(noMotion || !irqLineOne || irqLineTwo, 2)) else $error("sleep without cause");
	a_mode_swing: assert property ($changed(gyroPowerMode) |->
		(($past(gyroPowerMode) == PMODE_NORMAL) != (gyroPowerMode == PMODE_NORMAL)))
		else $error("move between low power modes");
	a_irq_clear: assert property ($fell(irq) |-> $past(apbWrite, 2))
		else $error("interrupt dropped without write");
	c_sleep: cover property ($fell(gyroPowerMode == PMODE_NORMAL));
	c_wake: cover property ($rose(gyroPowerMode == PMODE_NORMAL));
	c_irq: cover property ($rose(irq));
endmodule : icr_config_chk

// ==== tb/icr_host_model.sv ====
// Host processor model that runs APB transfers into the bank.
`timescale 1ns/1ps
module icr_host_model
	import icr_pkg::*;
(
	input wire logic core_clk, // Clock.
	output logic psel, // Select.
	output logic penable, // Enable.
	output logic pwrite, // Direction.
	output logic [ADDR_W-1:0] paddr, // Byte address.
	output logic [DATA_W-1:0] pwdata, // Write data.
	input wire logic [DATA_W-1:0] prdata, // Read data.
	input wire logic pready, // Ready.
	input wire logic pslverr, // Error.
	output logic hung // A transfer never got an answer.
);
	// The bus starts idle.
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		hung = 1'b0;
	end

	// One transfer; released lines show inverted values.
	task automatic xfer(input logic w, input logic [9:0] a, input logic [7:0] d,
		input logic [7:0] m, output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d & m};
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1 && n < 40)
		begin
			@(posedge core_clk);
			n++;
		end
		hung = hung | (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~paddr;
		pwdata <= ~pwdata;
		@(posedge core_clk);
	endtask : xfer
endmodule : icr_host_model

// ==== tb/testbench.sv ====
// Self-checking testbench for the configuration register bank.
`timescale 1ns/1ps
module testbench;
	import icr_pkg::*;
	localparam int HU = 8;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic psel, penable, pwrite, pready, pslverr, hung, err;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata, rd;
	logic [5:0] tiltAngle = 6'h3f;
	logic anyMotion = 1'b0, noMotion = 1'b0, irqLineOne = 1'b0, irqLineTwo = 1'b0;
	logic nvmProgReq = 1'b0;
	logic nvmProgStrobe, focGyroRun, threeWireSelect, primaryI2c, stabilizerLinkOn;
	logic magnetometerLinkOn, flatState, irq;
	logic [2:0] focAccAxisOn;
	logic [5:0] focAccTarget;
	logic [1:0] gyroPowerMode;
	logic [7:0] v;
	int badCount = 0, totalChecks = 0, seed = 23858;
	logic [7:0] regIdx [6] = '{IDX_FLAT_ANGLE, IDX_FLAT_DELAY, IDX_FOC_SETUP,
		IDX_NVM_GATE, IDX_PORT_SETUP, IDX_PWR_TRIG};
	logic [7:0] regMask [6] = '{WM_FLAT_ANGLE, WM_FLAT_DELAY, WM_FOC_SETUP,
		WM_NVM_GATE, WM_PORT_SETUP, WM_PWR_TRIG};
	logic [7:0] regRst [6] = '{RST_FLAT_ANGLE, RST_FLAT_DELAY, 8'h0, 8'h0, 8'h0, 8'h0};

	always #12.5 core_clk = ~core_clk;

	icr_config_regs #(.HOLD_UNIT_CYC(HU)) u_dut (.core_clk, .sys_rst, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .tiltAngle, .anyMotion,
		.noMotion, .irqLineOne, .irqLineTwo, .nvmProgReq, .nvmProgStrobe, .focGyroRun,
		.focAccAxisOn, .focAccTarget, .threeWireSelect, .primaryI2c, .stabilizerLinkOn,
		.magnetometerLinkOn, .gyroPowerMode, .flatState, .irq);
	icr_host_model u_host (.core_clk, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .hung);

	// Compare and count; a mismatch is reported at once.
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		totalChecks++;
		if (seen !== exp)
		begin
			badCount++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// A transfer that hung counts as a mismatch.
	task automatic completeRun;
		if (hung !== 1'b0)
			badCount++;
		if (badCount == 0 && totalChecks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : completeRun

	// Read-back value is the written byte with reserved bits dropped.
	function automatic logic [31:0] expBack(input int k, input logic [7:0] d);
		return {24'h0, d & regMask[k]};
	endfunction : expBack

	task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic [7:0] m);
		u_host.xfer(1'b1, {i, 2'b00}, d, m, rd, err);
	endtask : wr

	task automatic rdc(input string nm, input logic [7:0] i, input logic [31:0] exp);
		u_host.xfer(1'b0, {i, 2'b00}, 8'h0, 8'h0, rd, err);
		chk(nm, rd, exp);
	endtask : rdc

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask : tick

	// Main sequence.
	initial
	begin
		tick(12);
		sys_rst <= 1'b0;
		tick(1);
		for (int k = 0; k < 6; k++)
		begin
			rdc("reset value", regIdx[k], {24'h0, regRst[k]});
			v = 8'($random(seed));
			wr(regIdx[k], v, regMask[k]);
			rdc("read back", regIdx[k], expBack(k, v));
		end
		for (int c = 0; c < 4; c++)
		begin
			v = 8'($random(seed));
			v[1:0] = c[1:0];
			wr(IDX_FOC_SETUP, v, WM_FOC_SETUP);
			wr(IDX_PORT_SETUP, {2'b00, c[1:0], 3'b000, v[0]}, WM_PORT_SETUP);
			tick(1);
			chk("foc gyro", focGyroRun, v[6]);
			chk("foc axes", {focAccAxisOn, focAccTarget}, {|v[5:4], |v[3:2], |v[1:0], v[5:0]});
			chk("three wire", threeWireSelect, v[0]);
			chk("port mode", {primaryI2c, stabilizerLinkOn, magnetometerLinkOn},
				{c == 1, c == 1, c == 2});
		end
		// Unmapped word and misaligned byte are refused with zero data.
		for (int a = 0; a < 2; a++)
		begin
			u_host.xfer(1'b0, a ? 10'h19d : 10'h3fc, 8'h0, 8'h0, rd, err);
			chk("refused", {err, rd}, {1'b1, 32'h0});
		end
		nvmProgReq <= 1'b1;
		for (int p = 0; p < 2; p++)
		begin
			wr(IDX_NVM_GATE, p ? 8'h02 : 8'h00, WM_NVM_GATE);
			tick(2);
			chk("nvm strobe", nvmProgStrobe, p[0]);
		end
		nvmProgReq <= 1'b0;
		// Second reset restores defaults after random writes.
		sys_rst <= 1'b1;
		tick(3);
		sys_rst <= 1'b0;
		tick(1);
		wr(IDX_EVT_MASK, 8'h01, WM_EVT);
		wr(IDX_PWR_TRIG, 8'h74, WM_PWR_TRIG);
		noMotion <= 1'b1;
		tick(4);
		chk("mode suspend", gyroPowerMode, PMODE_SUSPEND);
		anyMotion <= 1'b1;
		tick(4);
		chk("wake wins", {gyroPowerMode, irq}, {PMODE_NORMAL, 1'b1});
		rdc("power status", IDX_PWR_STATUS, {30'h0, PMODE_NORMAL});
		rdc("event status", IDX_EVT_STATUS, 32'h1);
		wr(IDX_EVT_STATUS, 8'h01, WM_EVT);
		tick(1);
		chk("irq cleared", irq, 1'b0);
		// Shallow sleep; both wake conditions needed, no interrupt.
		wr(IDX_PWR_TRIG, 8'h1c, WM_PWR_TRIG);
		anyMotion <= 1'b0;
		tick(4);
		chk("mode fast", gyroPowerMode, PMODE_FAST);
		anyMotion <= 1'b1;
		noMotion <= 1'b0;
		tick(4);
		chk("one of two", gyroPowerMode, PMODE_FAST);
		wr(IDX_LINE_MODE, 8'h01, WM_LINE_MODE);
		irqLineOne <= 1'b1;
		tick(4);
		chk("both wake", {gyroPowerMode, irq}, {PMODE_NORMAL, 1'b0});
		// Flat entry waits out the hold time; hysteresis widens the exit angle.
		tiltAngle <= 6'(($random(seed) & 32'h7fffffff) % 9);
		tick(HU - 2);
		chk("flat held off", flatState, 1'b0);
		tick(HU + 8);
		chk("flat entered", flatState, 1'b1);
		tiltAngle <= 6'd9;
		tick(2 * HU + 6);
		chk("flat kept", flatState, 1'b1);
		tiltAngle <= 6'd10;
		tick(2 * HU + 6);
		chk("flat left", flatState, 1'b0);
		completeRun();
	end

	// Watchdog against a hung run.
	initial
	begin
		#2000000;
		badCount++;
		completeRun();
	end
endmodule : testbench

bind icr_config_regs icr_config_chk u_chk (.core_clk, .sys_rst, .psel, .penable, .pwrite,
	.pready, .anyMotion, .noMotion, .irqLineOne, .irqLineTwo, .nvmProgReq, .nvmProgStrobe,
	.focAccAxisOn, .focAccTarget, .gyroPowerMode, .irq);
